// File: logic/rsf_filter.sv
// Region security filter: region table, Wishbone slave and filter units.
// Assumes access inputs come from another clock and are held until done.
//
// Functional notes
// - Region 0 partly programmable, regions 1-8 fully programmable.
// - Protection bit 1 gives security: 0 Secure, 1 Non-secure.
// - One shared region table; each filter unit checks independently.
// - Non-secure accesses filtered by the presented source identity.
// - Region 0 covers every address not in another region.
// - Each region has a separate enable per filter unit.
// - Only enabled regions match; region 0 always enabled.
// - Region 0 settings used only when no enabled region matches.
// - Address in enabled region 1+ uses that region's settings.
// - Overlap hit sets status flag, optionally interrupt; outcome undefined.
// - Start address 4KB granular; region 0 start fixed zero.
// - End address last byte of 4KB block; region 0 end all ones.
// - Secure access granted solely by secure read/write enable bits.
// - Non-secure permission chosen by read or write source identity.
// - Each region has attributes word and source permit word.
// - Access not meeting region security is denied.
// - Source identity indexes permit bit; 1 grants, 0 denies.
// - Overlap with region 0 alone never sets the overlap flag.
// - Non-secure grant never implies Secure grant.
// - Separate 4-bit read and write source identities per filter.
//
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
module rsf_filter (
    input  wire logic                          CLK_I,
    input  wire logic                          RESETN_I,
    // Wishbone classic slave
    input  wire logic                          CYC_I,
    input  wire logic                          STB_I,
    input  wire logic                          WE_I,
    input  wire logic [11:0]                   ADR_I,
    input  wire logic [3:0]                    SEL_I,
    input  wire logic [31:0]                   DAT_I,
    output logic      [31:0]                   DAT_O,
    output logic                               ACK_O,
    // Read channels, one slice per filter unit
    input  wire logic [rsf_pkg::NF-1:0]        RD_REQ_I,
    input  wire logic [rsf_pkg::NF*32-1:0]     RD_ADDR_I,
    input  wire logic [rsf_pkg::NF*3-1:0]      READ_PROTECTION_IN_I,
    input  wire logic [rsf_pkg::NF*4-1:0]      READ_SOURCE_ID_I,
    // Write channels, one slice per filter unit
    input  wire logic [rsf_pkg::NF-1:0]        WR_REQ_I,
    input  wire logic [rsf_pkg::NF*32-1:0]     WR_ADDR_I,
    input  wire logic [rsf_pkg::NF*3-1:0]      WRITE_PROTECTION_IN_I,
    input  wire logic [rsf_pkg::NF*4-1:0]      WRITE_SOURCE_ID_I,
    // Check results
    output logic      [rsf_pkg::NF-1:0]        RD_DONE_O,
    output logic      [rsf_pkg::NF-1:0]        RD_GRANT_O,
    output logic      [rsf_pkg::NF-1:0]        WR_DONE_O,
    output logic      [rsf_pkg::NF-1:0]        WR_GRANT_O,
    output logic                               FILTER_IRQ_O
);
    import rsf_pkg::*;

    // ****************************************
    // Region table
    // ****************************************
    logic [PGW-1:0]  base_reg   [1:NREG-1];
    logic [PGW-1:0]  top_reg    [1:NREG-1];
    logic [NF-1:0]   en_reg     [1:NREG-1];
    logic            s_rd_reg   [0:NREG-1];
    logic            s_wr_reg   [0:NREG-1];
    logic [31:0]     permit_reg [0:NREG-1];
    logic [NF-1:0]   status_reg;
    logic [NF-1:0]   action_reg;
    logic [NF-1:0]   ovl_set;
    logic            ack_reg;

    // ****************************************
    // Bus decode
    // ****************************************
    logic            wb_hit;
    logic            wb_wr;
    logic            in_reg_blk;
    logic [3:0]      rg;
    logic [1:0]      wd;

    assign wb_hit     = CYC_I & STB_I & ~ack_reg;
    assign wb_wr      = wb_hit & WE_I;
    assign in_reg_blk = (ADR_I[11:8] == REG_BLOCK) && (ADR_I[7:4] < 4'(NREG));
    assign rg         = ADR_I[7:4];
    assign wd         = ADR_I[3:2];

    // Byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Read view of one register; region 0 shows its fixed fields
    function automatic logic [31:0] rd_view(input logic [3:0] r,
                                            input logic [1:0] w);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (w)
            WD_BASE: begin
                if (r != 4'h0) begin
                    v = {base_reg[r], 12'h000};
                end
            end
            WD_TOP: begin
                v = (r == 4'h0) ? 32'hffff_ffff : {top_reg[r], 12'hfff};
            end
            WD_ATTR: begin
                v[ATTR_EN_LSB +: NF] = (r == 4'h0) ? {NF{1'b1}} : en_reg[r];
                v[ATTR_S_RD] = s_rd_reg[r];
                v[ATTR_S_WR] = s_wr_reg[r];
            end
            default: begin
                v = permit_reg[r];
            end
        endcase
        return v;
    endfunction

    // ****************************************
    // Wishbone answer
    // ****************************************
    // One wait state: ack one edge after the request, dropped the next
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ack_reg <= 1'b0;
            DAT_O   <= 32'h0000_0000;
        end else begin
            ack_reg <= wb_hit;
            if (wb_hit && !WE_I) begin
                if (ADR_I == OFS_STATUS) begin
                    DAT_O <= {{(32-NF){1'b0}}, status_reg};
                end else if (ADR_I == OFS_ACTION) begin
                    DAT_O <= {{(32-NF){1'b0}}, action_reg};
                end else if (in_reg_blk) begin
                    DAT_O <= rd_view(rg, wd);
                end else begin
                    DAT_O <= 32'h0000_0000;  // Unmapped reads as zero
                end
            end
        end
    end
    assign ACK_O = ack_reg;

    // ****************************************
    // Region register writes
    // ****************************************
    // Region 0 has no start, end or enable storage; those are fixed
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            for (int r = 0; r < NREG; r++) begin
                s_rd_reg[r]   <= 1'b0;
                s_wr_reg[r]   <= 1'b0;
                permit_reg[r] <= RST_PERMIT;
            end
            for (int r = 1; r < NREG; r++) begin
                base_reg[r] <= RST_PAGE;
                top_reg[r]  <= RST_PAGE;
                en_reg[r]   <= RST_EN;
            end
        end else if (wb_wr && in_reg_blk) begin
            case (wd)
                WD_BASE: begin
                    if (rg != 4'h0) begin
                        base_reg[rg] <= PGW'(merge({base_reg[rg], 12'h000},
                                                   DAT_I, SEL_I) >> PG_LSB);
                    end
                end
                WD_TOP: begin
                    if (rg != 4'h0) begin
                        top_reg[rg] <= PGW'(merge({top_reg[rg], 12'hfff},
                                                  DAT_I, SEL_I) >> PG_LSB);
                    end
                end
                WD_ATTR: begin
                    if (SEL_I[0] && rg != 4'h0) begin
                        en_reg[rg] <= DAT_I[ATTR_EN_LSB +: NF];
                    end
                    if (SEL_I[3]) begin
                        s_rd_reg[rg] <= DAT_I[ATTR_S_RD];
                        s_wr_reg[rg] <= DAT_I[ATTR_S_WR];
                    end
                end
                default: begin
                    permit_reg[rg] <= merge(permit_reg[rg], DAT_I, SEL_I);
                end
            endcase
        end
    end

    // ****************************************
    // Overlap status and interrupt
    // ****************************************
    // Write one to clear; a new overlap in the same cycle wins
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            status_reg <= RST_FLAGS;
            action_reg <= RST_FLAGS;
        end else begin
            if (wb_wr && ADR_I == OFS_ACTION && SEL_I[0]) begin
                action_reg <= DAT_I[NF-1:0];
            end
            if (wb_wr && ADR_I == OFS_STATUS && SEL_I[0]) begin
                status_reg <= (status_reg & ~DAT_I[NF-1:0]) | ovl_set;
            end else begin
                status_reg <= status_reg | ovl_set;
            end
        end
    end

    // Level interrupt, registered so it is clean
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            FILTER_IRQ_O <= 1'b0;
        end else begin
            FILTER_IRQ_O <= |(status_reg & action_reg);
        end
    end

    // ****************************************
    // Access check
    // ****************************************
    // Returns {overlap, grant} for one access on filter f
    function automatic logic [1:0] check(input logic [PGW-1:0] pg,
                                         input logic [IDW-1:0] sid,
                                         input logic           ns,
                                         input logic           wr,
                                         input int             f);
        logic [3:0] sel;
        int         cnt;
        logic       ok;
        sel = 4'h0;
        cnt = 0;
        for (int r = NREG - 1; r >= 1; r--) begin
            if (en_reg[r][f] && pg >= base_reg[r] && pg <= top_reg[r]) begin
                sel = 4'(r);
                cnt = cnt + 1;
            end
        end
        // sel stays 0 only when no enabled higher region matched
        if (ns) begin
            ok = wr ? permit_reg[sel][PERMIT_WR_LSB + int'(sid)]
                    : permit_reg[sel][int'(sid)];
        end else begin
            ok = wr ? s_wr_reg[sel] : s_rd_reg[sel];
        end
        return {cnt > 1, ok};
    endfunction

    // ****************************************
    // Input synchronisers
    // ****************************************
    // Bundles are held by the master until done, so bits settle together
    localparam int SW = NF * 80;
    logic [SW-1:0] in_raw;
    logic [SW-1:0] sync1_reg;
    logic [SW-1:0] sync2_reg;

    assign in_raw = {RD_REQ_I, RD_ADDR_I, READ_PROTECTION_IN_I, READ_SOURCE_ID_I,
                     WR_REQ_I, WR_ADDR_I, WRITE_PROTECTION_IN_I, WRITE_SOURCE_ID_I};

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= in_raw;
            sync2_reg <= sync1_reg;
        end
    end

    logic [NF-1:0]    rq_s;
    logic [NF*32-1:0] ra_s;
    logic [NF*3-1:0]  rp_s;
    logic [NF*4-1:0]  ri_s;
    logic [NF-1:0]    wq_s;
    logic [NF*32-1:0] wa_s;
    logic [NF*3-1:0]  wp_s;
    logic [NF*4-1:0]  wi_s;

    assign {rq_s, ra_s, rp_s, ri_s, wq_s, wa_s, wp_s, wi_s} = sync2_reg;

    // ****************************************
    // Filter units
    // ****************************************
    // Each unit sees the shared table but checks on its own
    logic [NF-1:0] rq_prev_reg;
    logic [NF-1:0] wq_prev_reg;
    logic [NF-1:0] rd_fire;
    logic [NF-1:0] wr_fire;
    logic [1:0]    rd_res [NF];
    logic [1:0]    wr_res [NF];

    for (genvar f = 0; f < NF; f++) begin : g_unit
        assign rd_fire[f] = rq_s[f] & ~rq_prev_reg[f];
        assign wr_fire[f] = wq_s[f] & ~wq_prev_reg[f];
        always_comb begin  // Re-runs on table edits too, not only on new accesses
            rd_res[f] = check(ra_s[32*f + PG_LSB +: PGW], ri_s[4*f +: IDW],
                              rp_s[3*f + PROT_NS_BIT], 1'b0, f);
            wr_res[f] = check(wa_s[32*f + PG_LSB +: PGW], wi_s[4*f +: IDW],
                              wp_s[3*f + PROT_NS_BIT], 1'b1, f);
        end
        assign ovl_set[f] = (rd_fire[f] & rd_res[f][1]) | (wr_fire[f] & wr_res[f][1]);
    end

    // Done pulses one cycle per new request; grant stands until next check
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rq_prev_reg <= '0;
            wq_prev_reg <= '0;
            RD_DONE_O   <= '0;
            RD_GRANT_O  <= '0;
            WR_DONE_O   <= '0;
            WR_GRANT_O  <= '0;
        end else begin
            rq_prev_reg <= rq_s;
            wq_prev_reg <= wq_s;
            RD_DONE_O   <= rd_fire;
            WR_DONE_O   <= wr_fire;
            for (int f = 0; f < NF; f++) begin
                if (rd_fire[f]) begin
                    RD_GRANT_O[f] <= rd_res[f][0];
                end
                if (wr_fire[f]) begin
                    WR_GRANT_O[f] <= wr_res[f][0];
                end
            end
        end
    end
endmodule

// File: logic/rsf_pkg.sv
// Constants for the region security filter: sizes, register map, fields.
// Assumes a 32-bit classic Wishbone register bus and 32-bit access addresses.
package rsf_pkg;
    // ****************************************
    // Sizes
    // ****************************************
    localparam int NF     = 2;             // Filter units
    localparam int NREG   = 9;             // Region 0 plus regions 1-8
    localparam int AW     = 32;            // Access address width
    localparam int PGW    = 20;            // Address bits above the 4KB page
    localparam int PG_LSB = 12;            // Low bits implied by 4KB blocks
    localparam int IDW    = 4;             // Source identity width
    localparam int NIDS   = 16;            // Source identities
    localparam int PROT_NS_BIT = 1;        // Protection bit giving security

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [11:0] OFS_STATUS = 12'h000;  // Overlap flags, W1C
    localparam logic [11:0] OFS_ACTION = 12'h004;  // Overlap irq enables
    localparam logic [3:0]  REG_BLOCK  = 4'h1;     // Region block at 0x100
    localparam logic [1:0]  WD_BASE    = 2'h0;     // +0x0 start address
    localparam logic [1:0]  WD_TOP     = 2'h1;     // +0x4 end address
    localparam logic [1:0]  WD_ATTR    = 2'h2;     // +0x8 attributes
    localparam logic [1:0]  WD_PERMIT  = 2'h3;     // +0xc source permit word

    // ****************************************
    // Attributes and permit word fields
    // ****************************************
    localparam int ATTR_EN_LSB = 0;        // Per-filter enables [NF-1:0]
    localparam int ATTR_S_RD   = 30;       // Secure read enable
    localparam int ATTR_S_WR   = 31;       // Secure write enable
    localparam int PERMIT_WR_LSB = 16;     // Write identity enables [31:16]

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [PGW-1:0]  RST_PAGE   = 20'h00000;
    localparam logic [31:0]     RST_PERMIT = 32'h0000_0000;
    localparam logic [NF-1:0]   RST_EN     = 2'h0;
    localparam logic [NF-1:0]   RST_FLAGS  = 2'h0;
endpackage

// File: tb/rsf_access_master.sv
// Upstream master model for one access channel of one filter unit.
// Assumes it is called just after a rising edge of clk_i.
`timescale 1ns/10ps
module rsf_access_master (
    input  wire logic        clk_i,
    output logic             req_o,
    output logic [31:0]      addr_o,
    output logic [2:0]       prot_o,
    output logic [3:0]       sid_o,
    input  wire logic        done_i,
    input  wire logic        grant_i
);
    // Idle at time zero
    initial begin
        req_o = 1'b0;
        addr_o = 32'h0;
        prot_o = 3'h0;
        sid_o = 4'h0;
    end

    // Hold everything until done, then scramble so stale values never help
    task automatic access(input logic [31:0] a, input logic [2:0] p,
                          input logic [3:0] id, input int dly, output logic g);
        int n;
        g = 1'bx;
        repeat (dly) @(posedge clk_i);
        req_o  <= 1'b1;
        addr_o <= a;
        prot_o <= p;
        sid_o  <= id;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (done_i === 1'b1) begin
                g = grant_i;
                break;
            end
        end
        req_o  <= 1'b0;
        addr_o <= ~a;
        prot_o <= ~p;
        sid_o  <= ~id;
        repeat (3) @(posedge clk_i);
    endtask
endmodule

// File: tb/rsf_filter_monitor.sv
// Port checker for the region security filter: bus and channel timing.
// Assumes two filter units; bound onto rsf_filter after the module.
`timescale 1ns/10ps
module rsf_filter_monitor
    import rsf_pkg::*;
(
    input wire logic                   CLK_I,
    input wire logic                   RESETN_I,
    input wire logic                   CYC_I,
    input wire logic                   STB_I,
    input wire logic                   ACK_O,
    input wire logic [rsf_pkg::NF-1:0] RD_REQ_I,
    input wire logic [rsf_pkg::NF-1:0] WR_REQ_I,
    input wire logic [rsf_pkg::NF-1:0] RD_DONE_O,
    input wire logic [rsf_pkg::NF-1:0] WR_DONE_O,
    input wire logic [rsf_pkg::NF-1:0] RD_GRANT_O,
    input wire logic [rsf_pkg::NF-1:0] WR_GRANT_O,
    input wire logic                   FILTER_IRQ_O
);
    // ****************************************
    // Timing relations
    // ****************************************
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);

    // Request edge, then the check result three sampling edges on
    sequence s_rd0_start;
        $rose(RD_REQ_I[0]);
    endsequence
    sequence s_rd0_done;
        ##3 RD_DONE_O[0];
    endsequence

    a_ack_answer: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
        else $error("Bus request not answered next cycle");
    a_ack_pulse: assert property (ACK_O |=> !ACK_O)
        else $error("Acknowledge held too long");
    a_rd_latency: assert property (s_rd0_start |-> s_rd0_done)
        else $error("Read check result late on unit 0");
    a_wr_latency: assert property ($rose(WR_REQ_I[1]) |-> ##3 WR_DONE_O[1])
        else $error("Write check result late on unit 1");
    a_done_pulse: assert property (WR_DONE_O[0] |=> !WR_DONE_O[0])
        else $error("Write done longer than one cycle");
    a_done_cause: assert property (RD_DONE_O[1] |->
        $past(RD_REQ_I[1], 3) && !$past(RD_REQ_I[1], 4))
        else $error("Read done without a request edge");
    a_grant_hold: assert property (!WR_DONE_O[1] |-> $stable(WR_GRANT_O[1]))
        else $error("Write grant changed without done");
    a_reset_quiet: assert property ($rose(RESETN_I) |->
        !ACK_O && RD_DONE_O == 2'b00 && !FILTER_IRQ_O)
        else $error("Outputs active after reset release");
endmodule

bind rsf_filter rsf_filter_monitor u_mon (
    .CLK_I(CLK_I), .RESETN_I(RESETN_I), .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O),
    .RD_REQ_I(RD_REQ_I), .WR_REQ_I(WR_REQ_I), .RD_DONE_O(RD_DONE_O),
    .WR_DONE_O(WR_DONE_O), .RD_GRANT_O(RD_GRANT_O), .WR_GRANT_O(WR_GRANT_O),
    .FILTER_IRQ_O(FILTER_IRQ_O));

// File: tb/rsf_filter_tb.sv
// Self-checking bench for rsf_filter: Wishbone setup, random accesses.
// Assumes a two-unit filter and one access model per channel.
`timescale 1ns/10ps
module rsf_filter_tb;
    import rsf_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [11:0] adr = 12'h0;
    logic [3:0]  sel = 4'hf;
    logic [31:0] dw = 32'h0;
    wire  [31:0] dr;
    wire         ack, irq;
    wire  [1:0]  rq, wq, rdn, rg, wdn, wg;
    wire  [63:0] ra, wa;
    wire  [5:0]  rp, wp;
    wire  [7:0]  rs, ws;
    int          errors = 0;
    int          n_checks = 0;
    logic [19:0] bs [0:8] = '{default: 20'h0};
    logic [19:0] tp [0:8] = '{0: 20'hfffff, default: 20'h0};
    logic [31:0] at [0:8] = '{default: 32'h0};
    logic [31:0] pm [0:8] = '{default: 32'h0};

    always #50 clk = ~clk;

    rsf_filter DUT (
        .CLK_I(clk), .RESETN_I(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .ADR_I(adr), .SEL_I(sel), .DAT_I(dw), .DAT_O(dr), .ACK_O(ack),
        .RD_REQ_I(rq), .RD_ADDR_I(ra), .READ_PROTECTION_IN_I(rp), .READ_SOURCE_ID_I(rs),
        .WR_REQ_I(wq), .WR_ADDR_I(wa), .WRITE_PROTECTION_IN_I(wp), .WRITE_SOURCE_ID_I(ws),
        .RD_DONE_O(rdn), .RD_GRANT_O(rg), .WR_DONE_O(wdn), .WR_GRANT_O(wg),
        .FILTER_IRQ_O(irq));

    // One read and one write master per filter unit
    for (genvar f = 0; f < 2; f++) begin : g_ch
        rsf_access_master u_r (.clk_i(clk), .req_o(rq[f]), .addr_o(ra[32*f+:32]),
            .prot_o(rp[3*f+:3]), .sid_o(rs[4*f+:4]), .done_i(rdn[f]), .grant_i(rg[f]));
        rsf_access_master u_w (.clk_i(clk), .req_o(wq[f]), .addr_o(wa[32*f+:32]),
            .prot_o(wp[3*f+:3]), .sid_o(ws[4*f+:4]), .done_i(wdn[f]), .grant_i(wg[f]));
    end

    // ****************************************
    // Tasks and reference functions
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Classic single cycle; waits on ack, never on a fixed count
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dw  <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = dr;
        if (ack !== 1'b1) begin
            errors++;
            close_out();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    // Region 0 bounds are fixed, so only its permissions enter the model
    task automatic set_reg(input int r, input logic [19:0] b, input logic [19:0] t,
                           input logic [31:0] a, input logic [31:0] p);
        logic [31:0] q;
        wb(1'b1, 12'(256 + 16 * r), {b, 12'h000}, q);
        wb(1'b1, 12'(260 + 16 * r), {t, 12'hfff}, q);
        wb(1'b1, 12'(264 + 16 * r), a, q);
        wb(1'b1, 12'(268 + 16 * r), p, q);
        at[r] = a;
        pm[r] = p;
        if (r > 0) begin
            bs[r] = b;
            tp[r] = t;
        end
    endtask

    function automatic logic exp_g(input int f, input bit w, input logic [31:0] a,
                                   input logic ns, input logic [3:0] id);
        int m;
        m = 0;
        for (int r = 1; r < NREG; r++) begin
            if (at[r][ATTR_EN_LSB + f] && a[31:12] >= bs[r] && a[31:12] <= tp[r]) m = r;
        end
        if (ns) return pm[m][{w, id}];
        return at[m][w ? ATTR_S_WR : ATTR_S_RD];
    endfunction

    // Pages near region edges, one region per top nibble
    function automatic logic [31:0] rnd_addr();
        logic [11:0] lo;
        lo = ($urandom % 2) ? 12'hfff : 12'($urandom);
        return {4'($urandom % 6), 8'h00, 8'($urandom % 18), lo};
    endfunction

    task automatic go(input int f, input bit w);
        logic [31:0] a;
        logic [2:0]  p;
        logic [3:0]  id;
        logic        g;
        int          k;
        a = rnd_addr();
        p = 3'($urandom);
        id = 4'($urandom);
        k = $urandom % 3;
        case ({f[0], w})
            2'b00: g_ch[0].u_r.access(a, p, id, k, g);
            2'b01: g_ch[0].u_w.access(a, p, id, k, g);
            2'b10: g_ch[1].u_r.access(a, p, id, k, g);
            default: g_ch[1].u_w.access(a, p, id, k, g);
        endcase
        check(32'(g), 32'(exp_g(f, w, a, p[PROT_NS_BIT], id)));
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [31:0] q;
        void'($urandom(32'h518175ee));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        wb(1'b0, 12'h104, 32'h0, q);
        check(q, 32'hffff_ffff);
        wb(1'b0, 12'h108, 32'h0, q);
        check(q, 32'h0000_0003);
        wb(1'b0, 12'h118, 32'h0, q);
        check(q, 32'h0);
        wb(1'b1, 12'h0f0, 32'hffff_ffff, q);
        wb(1'b0, 12'h0f0, 32'h0, q);
        check(q, 32'h0);
        set_reg(0, 20'h12345, 20'h00001, 32'hc000_0000, 32'h0001_0001);
        wb(1'b0, 12'h100, 32'h0, q);
        check(q, 32'h0);
        wb(1'b0, 12'h108, 32'h0, q);
        check(q, 32'hc000_0003);
        // Random non-overlapping layouts, all four channels at once
        for (int k = 0; k < 6; k++) begin
            set_reg(0, 20'h0, 20'h0, $urandom & 32'hc000_0000, $urandom);
            for (int r = 1; r < 5; r++) begin
                set_reg(r, {4'(r), 16'h0}, {4'(r), 16'($urandom % 16)},
                        ($urandom & 32'hc000_0000) | ($urandom % 4), $urandom);
            end
            repeat (8) begin
                fork
                    go(0, 1'b0);
                    go(0, 1'b1);
                    go(1, 1'b0);
                    go(1, 1'b1);
                join
            end
        end
        wb(1'b0, OFS_STATUS, 32'h0, q);
        check(q, 32'h0);
        // Overlap on unit 0 only; unit 1 sees a single region
        set_reg(1, 20'h10000, 20'h10003, 32'h0000_0003, 32'h0);
        set_reg(5, 20'h10002, 20'h10008, 32'h0000_0001, 32'h0);
        fork
            g_ch[0].u_r.access(32'h1000_2000, 3'h0, 4'h0, 0, q[0]);
            g_ch[1].u_w.access(32'h1000_2000, 3'h0, 4'h0, 1, q[1]);
        join
        check(32'(q[1]), 32'h0);
        wb(1'b0, OFS_STATUS, 32'h0, q);
        check(q, 32'h1);
        check(32'(irq), 32'h0);
        wb(1'b1, OFS_ACTION, 32'h1, q);
        repeat (2) @(posedge clk);
        check(32'(irq), 32'h1);
        wb(1'b1, OFS_STATUS, 32'h1, q);
        repeat (2) @(posedge clk);
        check(32'(irq), 32'h0);
        close_out();
    end

    // Hang guard
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        close_out();
    end
endmodule
